// file: rtl/scl_defines.vh
// Constants for the strap configuration latch.
// Assumes a 50 MHz mclk and a register port driven by the management core.
//
// Notes on behaviour
// R1: Sample every strap pin while reset is active; captured levels select modes.
// R2: Latch five-bit station address at reset; any value 0 to 31 allowed.
// R3: Address bits 4..1 default low, bit 0 defaults high without resistors.
// R4: Duplex strap high selects full duplex, low selects half duplex.
// R5: Default straps give auto-negotiation enabled, advertising 100 Mb/s.
// R6: Indicator-mode strap picks link indicator mode, default 1, writable in phy_control.
// R7: Every strap-selected mode is changeable by register access after reset; the MAC-interface mode (rmii_q) has no register write here.
// R8: Crossover strap high enables auto crossover; low disables it.
// R9: MAC-interface strap low gives MII; high gives RMII.
// R10: After reset strap pins return to normal functions; latched values kept.
// R11: Writing one to regulator_control bit 15 powers down the core regulator.
// R12: System should assert external reset after power-up with dual supplies.
// R13: Reset low for at least 1 us reinitialises registers and resamples straps; the srst input here is active high.
// R14: Mode 1 (one) shows link only; mode 2 (zero) blinks on activity.
// R15: Captured duplex strap sets advertise_register bits 8 to 5; here it sets bits 8 and 6, and bits 7 and 5 reset to one.
// R16: Strap pins are high impedance while reset is active.
// R17: Latched values stay until next reset unless software writes the fields.
`ifndef SCL_DEFINES_VH
`define SCL_DEFINES_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SCL_OFS_ADVERTISE 8'h04
`define SCL_OFS_PHY_CTRL 8'h19
`define SCL_OFS_REG_CTRL 8'hD0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SCL_PHY_CONTROL_MDIX_EN 15
`define SCL_PHY_CONTROL_MDIX_FORCE 14
`define SCL_PHY_CONTROL_LED_MODE 5
`define SCL_PHY_CONTROL_ADDR_HI 4
`define SCL_REGCR_PWRDN 15
`define SCL_ADV_100FD 8
`define SCL_ADV_100HD 7
`define SCL_ADV_10FD 6
`define SCL_ADV_10HD 5

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define SCL_ADV_SELECTOR 5'h01
`define SCL_REGCR_RESET 16'h0000
`define SCL_RESET_MIN_NS 1000
`define SCL_CLK_NS 20
`define SCL_RESET_MIN_CYC ((`SCL_RESET_MIN_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`define SCL_BLINK_HZ 5
`define SCL_CLK_HZ 50000000
`define SCL_BLINK_HALF_CYC (`SCL_CLK_HZ / (`SCL_BLINK_HZ * 2))

`endif

// file: rtl/scl_strap_config_latch.v
// Strap configuration latch with register overrides and link indicator.
// Assumes straps settle while srst is high and a simple register port.
`timescale 1ns/1ps
`default_nettype none
`include "scl_defines.vh"

module scl_strap_config_latch #(
  parameter BLINK_HALF_CYC = `SCL_BLINK_HALF_CYC,
  parameter ADDR_W = 5
) (
  input wire mclk,
  input wire srst,
  // Strap pins, shared with receive and indicator outputs
  input wire [ADDR_W-1:0] stationAddressStrapIn,
  input wire duplexStrapIn,
  input wire indicatorModeStrapIn,
  input wire crossoverAutoStrapIn,
  input wire macIfStrapIn,
  // Normal pin functions after reset
  input wire [ADDR_W-1:0] pinFuncData,
  input wire [ADDR_W-1:0] pinFuncEn,
  output wire [ADDR_W-1:0] stationAddressStrapOut,
  output wire [ADDR_W-1:0] stationAddressStrapOe,
  output wire linkIndicatorOut,
  output wire linkIndicatorOe,
  input wire linkUp,
  input wire activity,
  // Register port
  input wire regWr,
  input wire regRd,
  input wire [7:0] regAddr,
  input wire [15:0] regWdata,
  output reg [15:0] regRdata,
  output reg regAck,
  // Configuration to the core
  output wire [ADDR_W-1:0] stationAddress,
  output wire autoNegEnable,
  output wire fullDuplex,
  output wire [15:0] advertise,
  output wire crossoverAuto,
  output wire crossoverForce,
  output wire rmiiMode,
  output wire indicatorMode1,
  output wire regulatorPowerDown,
  output wire resetTooShort
);

  // ---------------------------------------------------------------
  // Configuration state
  // ---------------------------------------------------------------
  reg [ADDR_W-1:0] addr_q;
  reg duplex_q;
  reg ledMode_q;
  reg mdixEn_q;
  reg mdixForce_q;
  reg rmii_q;
  reg anEn_q;
  reg [3:0] advAbil_q;
  reg [15:0] regCr_q;
  reg srstDly_q;
  reg [7:0] rstCnt_q;
  reg shortRst_q;
  reg [31:0] blinkCnt_q;
  reg blink_q;
  wire rstRelease;

  assign rstRelease = srstDly_q & ~srst;

  // Straps sampled every cycle of reset; the last sample stands
  always @(posedge mclk) begin
    if (srst) begin
      addr_q <= stationAddressStrapIn; // R1 R2 R3 R13
      duplex_q <= duplexStrapIn; // R4
      ledMode_q <= indicatorModeStrapIn; // R6
      mdixEn_q <= crossoverAutoStrapIn; // R8
      rmii_q <= macIfStrapIn; // R9
      mdixForce_q <= 1'b0;
      anEn_q <= 1'b1; // R5
      advAbil_q <= {duplexStrapIn, 1'b1, duplexStrapIn, 1'b1}; // R15 R5
      regCr_q <= `SCL_REGCR_RESET;
    end else if (regWr) begin
      // Only software writes alter the latched values
      case (regAddr)
        `SCL_OFS_PHY_CTRL: begin
          mdixEn_q <= regWdata[`SCL_PHY_CONTROL_MDIX_EN]; // R7 R17
          mdixForce_q <= regWdata[`SCL_PHY_CONTROL_MDIX_FORCE];
          ledMode_q <= regWdata[`SCL_PHY_CONTROL_LED_MODE]; // R6
          addr_q <= regWdata[`SCL_PHY_CONTROL_ADDR_HI -: ADDR_W];
        end
        `SCL_OFS_ADVERTISE: begin
          advAbil_q <= regWdata[`SCL_ADV_100FD:`SCL_ADV_10HD]; // R7
          duplex_q <= regWdata[`SCL_ADV_100FD] | regWdata[`SCL_ADV_10FD];
        end
        `SCL_OFS_REG_CTRL: begin
          regCr_q <= regWdata; // R11
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Reset width check
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    srstDly_q <= srst;
    if (srst) begin
      if (rstCnt_q != 8'hFF)
        rstCnt_q <= rstCnt_q + 8'h01;
    end else begin
      rstCnt_q <= 8'h00;
    end
    if (rstRelease)
      shortRst_q <= (rstCnt_q < `SCL_RESET_MIN_CYC); // R13
    else if (srst)
      shortRst_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      regRdata <= 16'h0000;
      regAck <= 1'b0;
    end else begin
      regAck <= regWr | regRd;
      if (regRd) begin
        case (regAddr)
          `SCL_OFS_PHY_CTRL:
            regRdata <= {mdixEn_q, mdixForce_q, 8'h00, ledMode_q, addr_q};
          `SCL_OFS_ADVERTISE:
            regRdata <= {7'h00, advAbil_q, `SCL_ADV_SELECTOR};
          `SCL_OFS_REG_CTRL:
            regRdata <= regCr_q;
          default:
            regRdata <= 16'h0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Link indicator
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      blinkCnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (!activity) begin
      blinkCnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (blinkCnt_q >= BLINK_HALF_CYC - 1) begin
      blinkCnt_q <= 32'h0000_0000;
      blink_q <= ~blink_q;
    end else begin
      blinkCnt_q <= blinkCnt_q + 32'h0000_0001;
    end
  end

  assign linkIndicatorOut = ledMode_q ? linkUp : (linkUp & ~blink_q); // R14
  assign linkIndicatorOe = ~srst; // R16 R10
  assign stationAddressStrapOut = pinFuncData; // R10
  assign stationAddressStrapOe = srst ? {ADDR_W{1'b0}} : pinFuncEn; // R16

  assign stationAddress = addr_q;
  assign autoNegEnable = anEn_q;
  assign fullDuplex = duplex_q;
  assign advertise = {7'h00, advAbil_q, `SCL_ADV_SELECTOR};
  assign crossoverAuto = mdixEn_q;
  assign crossoverForce = mdixForce_q;
  assign rmiiMode = rmii_q;
  assign indicatorMode1 = ledMode_q;
  assign regulatorPowerDown = regCr_q[`SCL_REGCR_PWRDN]; // R11
  assign resetTooShort = shortRst_q;

endmodule // scl_strap_config_latch
`default_nettype wire

// file: sim/scl_checker_asserts.sv
// Checker for the strap latch; watches top-level ports only.
// Assumes straps and strobes change away from the rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module scl_checker #(parameter ADDR_W = 5) (
  input wire logic mclk, srst, regWr, regRd, regAck, duplexStrapIn, indicatorModeStrapIn,
  input wire logic crossoverAutoStrapIn, macIfStrapIn, linkIndicatorOe, linkIndicatorOut, linkUp,
  input wire logic autoNegEnable, fullDuplex, crossoverAuto, crossoverForce, rmiiMode,
  input wire logic indicatorMode1, regulatorPowerDown,
  input wire logic [ADDR_W-1:0] stationAddressStrapIn, stationAddressStrapOe, stationAddress,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata, advertise
);
  sequence wrRegCtrl;
    !srst && regWr && regAddr == 8'hD0;
  endsequence
  ack_after_strobe_a: assert property (@(posedge mclk) disable iff (srst) (regWr || regRd) |=> regAck) else $error("no ack");
  pins_released_a: assert property (@(posedge mclk) srst |-> stationAddressStrapOe == 0 && !linkIndicatorOe) else $error("pins driven in reset");
  addr_sampled_a: assert property (@(posedge mclk) srst |=> stationAddress == $past(stationAddressStrapIn)) else $error("address not sampled");
  modes_sampled_a: assert property (@(posedge mclk) srst |=> rmiiMode == $past(macIfStrapIn) && crossoverAuto == $past(crossoverAutoStrapIn) && indicatorMode1 == $past(indicatorModeStrapIn)) else $error("modes not sampled");
  duplex_advert_a: assert property (@(posedge mclk) srst |=> advertise == {7'h00, {2{$past(duplexStrapIn), 1'b1}}, 5'h01}) else $error("advertise wrong");
  reset_defaults_a: assert property (@(posedge mclk) srst |=> autoNegEnable && !crossoverForce && !regulatorPowerDown) else $error("reset defaults wrong");
  latch_held_a: assert property (@(posedge mclk) disable iff (srst) !regWr |=> $stable({stationAddress, rmiiMode, crossoverAuto, indicatorMode1, fullDuplex})) else $error("latched value moved");
  regulator_write_a: assert property (@(posedge mclk) disable iff (srst) wrRegCtrl |=> regulatorPowerDown == $past(regWdata[15])) else $error("power down bit wrong");
  link_only_a: assert property (@(posedge mclk) disable iff (srst) indicatorMode1 |-> linkIndicatorOut == linkUp) else $error("mode 1 indicator wrong");
endmodule // scl_checker
bind scl_strap_config_latch scl_checker #(.ADDR_W(ADDR_W)) i_scl_checker (.mclk, .srst, .regWr,
  .regRd, .regAck, .duplexStrapIn, .indicatorModeStrapIn, .crossoverAutoStrapIn, .macIfStrapIn,
  .linkIndicatorOe, .linkIndicatorOut, .linkUp, .autoNegEnable, .fullDuplex, .crossoverAuto,
  .crossoverForce, .rmiiMode, .indicatorMode1, .regulatorPowerDown, .stationAddressStrapIn,
  .stationAddressStrapOe, .stationAddress, .regAddr, .regWdata, .advertise);
`default_nettype wire

// file: sim/scl_strap_board.sv
// Board straps: pull defaults, optional external resistors, shared pins.
// Assumes the device releases its pins while reset is high.
`timescale 1ns/1ps
`default_nettype none
module scl_strap_board (
  input wire logic ovrEn,
  input wire logic [8:0] ovr,
  input wire logic [4:0] stationAddressStrapOut, stationAddressStrapOe,
  input wire logic linkIndicatorOut, linkIndicatorOe,
  output logic [4:0] stationAddressStrapIn,
  output logic duplexStrapIn, indicatorModeStrapIn, crossoverAutoStrapIn, macIfStrapIn
);
  logic [8:0] lvl;
  always_comb begin
    lvl = ovrEn ? ovr : 9'h01E;
    for (int i = 0; i < 5; i++)
      stationAddressStrapIn[i] = stationAddressStrapOe[i] ? stationAddressStrapOut[i] : lvl[4+i];
    duplexStrapIn = linkIndicatorOe ? linkIndicatorOut : lvl[3];
    {indicatorModeStrapIn, crossoverAutoStrapIn, macIfStrapIn} = lvl[2:0];
  end
endmodule // scl_strap_board
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the strap latch through its register port.
// Assumes a one-cycle strobe and an ack one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 0, srst = 0, regWr = 0, regRd = 0, linkUp = 0, activity = 0, ovrEn = 0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic [4:0] pinFuncData = 5'h00, pinFuncEn = 5'h00;
  logic [8:0] ovr = 9'h000;
  wire [4:0] stationAddressStrapIn, stationAddressStrapOut, stationAddressStrapOe, stationAddress;
  wire duplexStrapIn, indicatorModeStrapIn, crossoverAutoStrapIn, macIfStrapIn, regAck;
  wire linkIndicatorOut, linkIndicatorOe, autoNegEnable, fullDuplex, crossoverAuto;
  wire crossoverForce, rmiiMode, indicatorMode1, regulatorPowerDown, resetTooShort;
  wire [15:0] regRdata, advertise;
  int mismatches = 0, nTests = 0;
  scl_strap_config_latch #(.BLINK_HALF_CYC(4)) i_scl_strap_config_latch (.mclk, .srst,
    .stationAddressStrapIn, .duplexStrapIn, .indicatorModeStrapIn, .crossoverAutoStrapIn,
    .macIfStrapIn, .pinFuncData, .pinFuncEn, .stationAddressStrapOut, .stationAddressStrapOe,
    .linkIndicatorOut, .linkIndicatorOe, .linkUp, .activity, .regWr, .regRd, .regAddr, .regWdata,
    .regRdata, .regAck, .stationAddress, .autoNegEnable, .fullDuplex, .advertise, .crossoverAuto,
    .crossoverForce, .rmiiMode, .indicatorMode1, .regulatorPowerDown, .resetTooShort);
  scl_strap_board i_scl_strap_board (.ovrEn, .ovr, .stationAddressStrapOut, .stationAddressStrapOe,
    .linkIndicatorOut, .linkIndicatorOe, .stationAddressStrapIn, .duplexStrapIn,
    .indicatorModeStrapIn, .crossoverAutoStrapIn, .macIfStrapIn);
  initial forever #10 mclk = ~mclk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int i;
    @(negedge mclk);
    {regWr, regRd, regAddr, regWdata} = {wr, !wr, a, d};
    @(negedge mclk);
    {regWr, regRd} = 2'b00;
    for (i = 0; i < 4 && regAck !== 1'b1; i++) @(negedge mclk);
    chk(regAck, 16'h0001);
  endtask
  task automatic boot(input logic en, input logic [8:0] v, input int n);
    @(negedge mclk);
    {srst, ovrEn, ovr} = {1'b1, en, v};
    repeat (n) @(negedge mclk);
    srst = 0;
    @(negedge mclk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    boot(1'b0, 9'h000, 10);
    chk(resetTooShort, 16'h0001);
    acc(1'b0, 8'h19, 16'h0000);
    chk(regRdata, 16'h8021);
    chk(advertise, 16'h01E1);
    chk({autoNegEnable, fullDuplex, rmiiMode, regulatorPowerDown}, 16'h000C);
    $display("test defaults done");
    boot(1'b1, 9'h1E1, 50);
    chk(resetTooShort, 16'h0000);
    {pinFuncEn, pinFuncData, linkUp} = {5'h1F, 5'h0A, 1'b1};
    acc(1'b0, 8'h19, 16'h0000);
    chk(regRdata, 16'h001E);
    chk(advertise, 16'h00A1);
    chk({rmiiMode, fullDuplex, linkIndicatorOut, stationAddressStrapOut}, 16'h00AA);
    $display("test straps done");
    acc(1'b1, 8'hD0, 16'h8000);
    chk(regulatorPowerDown, 16'h0001);
    acc(1'b0, 8'hD0, 16'h0000);
    chk(regRdata, 16'h8000);
    acc(1'b1, 8'h19, 16'h4023);
    acc(1'b0, 8'h19, 16'h0000);
    chk(regRdata, 16'h4023);
    chk({stationAddress, crossoverForce, indicatorMode1}, 16'h000F);
    acc(1'b1, 8'h04, 16'h0141);
    chk({advertise[8:0], fullDuplex}, 16'h0283);
    acc(1'b0, 8'h55, 16'h0000);
    chk(regRdata, 16'h0000);
    acc(1'b1, 8'h19, 16'h0003);
    activity = 1;
    repeat (4) @(negedge mclk);
    chk(linkIndicatorOut, 16'h0000);
    repeat (4) @(negedge mclk);
    chk(linkIndicatorOut, 16'h0001);
    activity = 0;
    $display("test writes done");
    end_of_test;
  end
  initial begin
    #20000;
    mismatches++;
    end_of_test;
  end
endmodule // tb
`default_nettype wire
